// >>> src/bst_pkg.sv
// Constants, state and pin types for the boundary-scan test access port
// Functional notes
// - TMS and TDI sampled on rising test clock; all test operations except the asynchronous test reset follow that clock.
// - Test data output changes only on falling test clock edges.
// - While shifting, TDI bits enter the selected instruction, identification or bypass register.
// - Test data output driven only in Shift-DR and Shift-IR, otherwise high impedance.
// - Undriven TDI and TMS inputs read as logic high through pull-ups.
// - TMS steers the controller; transitions are evaluated on the test clock.
// - No automatic controller reset at power-up; state undefined until explicit reset.
// - TMS high for five consecutive test clock cycles resets the controller.
// - Low test reset input resets the controller asynchronously, without a clock edge.
// - FIFO data outputs stay high impedance until the controller has been reset.
package bst_pkg;

  localparam int         IR_LEN        = 4;
  localparam int         ID_LEN        = 32;
  localparam logic [3:0] IR_CAPTURE    = 4'h1;  // Fixed pattern loaded at Capture-IR
  localparam logic [3:0] INSTR_IDCODE  = 4'h2;  // Selects identification register
  localparam logic [3:0] INSTR_BYPASS  = 4'hF;  // All ones always selects bypass
  localparam logic [2:0] TLR_TMS_COUNT = 3'h5;  // TMS highs that force reset state
  localparam logic [0:0] BYPASS_CAPTURE = 1'h0;

  // Sixteen controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bst_state_type;

  // Pin levels that cross into the system clock domain together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bst_pins_type;

endpackage

// >>> src/bst_sync.sv
// Two-stage synchroniser for the test pins
`timescale 1ns/1ps
module bst_sync
  import bst_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input  wire logic             clk,   // System clock
  input  wire logic             rst,   // Asynchronous reset, high
  input  wire logic [WIDTH-1:0] d,     // Asynchronous levels
  output logic      [WIDTH-1:0] q      // Synchronised levels
);

  logic [WIDTH-1:0] meta;

  // First stage is read only by the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// >>> src/bst_tap.sv
// Boundary-scan test access port sampled on the system clock
`timescale 1ns/1ps
module bst_tap
  import bst_pkg::*;
#(
  parameter logic [ID_LEN-1:0] IDCODE_VALUE = 32'h1234_5001  // Arbitrary value, LSB one
)
(
  input  wire logic clk,           // System clock, 250 MHz
  input  wire logic rst,           // System reset, high, async
  input  wire logic tck,           // Test clock pin
  input  wire logic tms,           // Mode select pin level
  input  wire logic tms_driven,    // High while far end drives mode select
  input  wire logic tdi,           // Test data input pin level
  input  wire logic tdi_driven,    // High while far end drives data input
  input  wire logic trst_n,        // Test reset pin, low active, async
  output logic      tdo,           // Test data output level
  output logic      tdo_oe,        // High while test data output driven
  output logic      fifo_out_hiz   // High holds FIFO data outputs floating
);

  bst_pins_type      pins_raw;
  bst_pins_type      pins;
  logic              tck_d;
  logic              tck_rise;
  logic              tck_fall;
  bst_state_type     state;
  bst_state_type     next_state;
  logic              tap_ready;
  logic [IR_LEN-1:0] ir;
  logic [IR_LEN-1:0] ir_shift;
  logic [ID_LEN-1:0] dr_shift;
  logic              bypass_bit;
  logic              sel_idcode;
  logic              in_shift;

  // Undriven inputs float high through pull-ups
  always_comb
  begin
    pins_raw.tck = tck;
    pins_raw.tms = tms_driven ? tms : 1'b1;
    pins_raw.tdi = tdi_driven ? tdi : 1'b1;
  end

  bst_sync #(
    .WIDTH ($bits(bst_pins_type))
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins_raw),
    .q   (pins)
  );

  // Edge finder on the synchronised test clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tck_d <= 1'b0;
    else
      tck_d <= pins.tck;
  end

  assign tck_rise = pins.tck & ~tck_d;
  assign tck_fall = ~pins.tck & tck_d;

  // Standard sixteen-state transition table
  always_comb
  begin
    next_state = state;
    case (state)
      ST_TLR:      next_state = pins.tms ? ST_TLR      : ST_RTI;
      ST_RTI:      next_state = pins.tms ? ST_SEL_DR   : ST_RTI;
      ST_SEL_DR:   next_state = pins.tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   next_state = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_state = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_state = pins.tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: next_state = pins.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_state = pins.tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   next_state = pins.tms ? ST_SEL_DR   : ST_RTI;
      ST_SEL_IR:   next_state = pins.tms ? ST_TLR      : ST_CAP_IR;
      ST_CAP_IR:   next_state = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_state = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_state = pins.tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: next_state = pins.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_state = pins.tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   next_state = pins.tms ? ST_SEL_DR   : ST_RTI;
      default:     next_state = ST_TLR;
    endcase
  end

  // Controller state; system reset gives no valid TAP state, only trst or TMS does.
  // Parking at Run-Test/Idle keeps simulation defined while tap_ready stays low.
  always_ff @(posedge clk or posedge rst or negedge trst_n)
  begin
    if (rst)
      state <= ST_RTI;
    else if (!trst_n)
      state <= ST_TLR;
    else if (tck_rise)
      state <= next_state;
  end

  // Sticky proof that the controller was reset properly
  always_ff @(posedge clk or posedge rst or negedge trst_n)
  begin
    if (rst)
      tap_ready <= 1'b0;
    else if (!trst_n)
      tap_ready <= 1'b1;
    else if (state == ST_TLR)
      tap_ready <= 1'b1;
  end

  assign fifo_out_hiz = ~tap_ready;

  // Instruction path: capture, shift, update
  always_ff @(posedge clk or posedge rst or negedge trst_n)
  begin
    if (rst)
    begin
      ir       <= INSTR_IDCODE;
      ir_shift <= '0;
    end
    else if (!trst_n)
    begin
      ir       <= INSTR_IDCODE;
      ir_shift <= '0;
    end
    else if (tck_rise)
    begin
      case (state)
        ST_TLR:      ir       <= INSTR_IDCODE;
        ST_CAP_IR:   ir_shift <= IR_CAPTURE;
        ST_SHIFT_IR: ir_shift <= {pins.tdi, ir_shift[IR_LEN-1:1]};
        ST_UPD_IR:   ir       <= ir_shift;
        default:     ir       <= ir;
      endcase
    end
  end

  // Unknown codes fall back to bypass, the safe one-bit path
  assign sel_idcode = (ir == INSTR_IDCODE);
  assign in_shift   = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);

  // Data path: identification and one-bit bypass
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dr_shift   <= '0;
      bypass_bit <= 1'b0;
    end
    else if (tck_rise)
    begin
      if (state == ST_CAP_DR)
      begin
        dr_shift   <= IDCODE_VALUE;
        bypass_bit <= BYPASS_CAPTURE;
      end
      else if (state == ST_SHIFT_DR)
      begin
        if (sel_idcode)
          dr_shift <= {pins.tdi, dr_shift[ID_LEN-1:1]};
        else
          bypass_bit <= pins.tdi;
      end
    end
  end

  // Output stage moves only on the falling test clock edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe <= in_shift;
      if (state == ST_SHIFT_IR)
        tdo <= ir_shift[0];
      else if (state == ST_SHIFT_DR)
        tdo <= sel_idcode ? dr_shift[0] : bypass_bit;
    end
  end

  // Helper: consecutive TMS highs seen at rising test clock edges
  logic [2:0] tms_run;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tms_run <= 3'h0;
    else if (tck_rise)
      tms_run <= !pins.tms ? 3'h0 : (tms_run == TLR_TMS_COUNT ? tms_run : tms_run + 3'h1);
  end

  chk_five_tms_reset: assert property (
    @(posedge clk) disable iff (rst || !trst_n)
    (tms_run == TLR_TMS_COUNT) |-> (state == ST_TLR))
    else $error("five TMS highs did not reach reset state");

  chk_state_on_rise: assert property (
    @(posedge clk) disable iff (rst || !trst_n)
    (state != $past(state)) |-> $past(tck_rise))
    else $error("controller moved without a rising test clock");

  chk_trst_async: assert property (
    @(posedge clk) disable iff (rst)
    !trst_n |-> (state == ST_TLR))
    else $error("test reset low but controller not in reset state");

  chk_tdo_falling_only: assert property (
    @(posedge clk) disable iff (rst)
    (tdo != $past(tdo)) || (tdo_oe != $past(tdo_oe)) |-> $past(tck_fall))
    else $error("test data output changed away from falling edge");

  chk_tdo_hiz_idle: assert property (
    @(posedge clk) disable iff (rst)
    (tck_fall && !in_shift) |=> !tdo_oe)
    else $error("test data output driven outside shift states");

  chk_ready_on_reset: assert property (
    @(posedge clk) disable iff (rst || !trst_n)
    $rose(tap_ready) |-> $past(state == ST_TLR))
    else $error("ready flag rose without controller reset");

  chk_fifo_hiz_hold: assert property (
    @(posedge clk) disable iff (rst || !trst_n)
    (fifo_out_hiz && state != ST_TLR && trst_n) |=> fifo_out_hiz)
    else $error("FIFO outputs released before controller reset");

  chk_bypass_one_bit: assert property (
    @(posedge clk) disable iff (rst || !trst_n)
    (tck_rise && state == ST_SHIFT_DR && !sel_idcode) |=> (bypass_bit == $past(pins.tdi)))
    else $error("bypass bit did not take TDI");

  chk_ir_capture: assert property (
    @(posedge clk) disable iff (rst || !trst_n)
    (tck_rise && state == ST_CAP_IR) |=> (ir_shift == IR_CAPTURE))
    else $error("instruction capture pattern wrong");

  cov_tms_reset: cover property (
    @(posedge clk) disable iff (rst) (tms_run == TLR_TMS_COUNT) && trst_n);

  cov_shift_idcode: cover property (
    @(posedge clk) disable iff (rst) tck_fall && state == ST_SHIFT_DR && sel_idcode);

  cov_update_ir: cover property (
    @(posedge clk) disable iff (rst) tck_rise && state == ST_UPD_IR);

endmodule

// >>> tb/bst_host.sv
// Model of the external test controller that drives the scan pins
`timescale 1ns/1ps
module bst_host
  import bst_pkg::*;
(
  input  wire logic clk,         // Bench system clock
  input  wire logic tdo,         // Test data output level
  input  wire logic tdo_oe,      // Test data output enable
  output logic      tck,         // Test clock, still between frames
  output logic      tms,         // Mode select level
  output logic      tms_driven,  // High while mode select driven
  output logic      tdi,         // Test data level
  output logic      tdi_driven,  // High while data input driven
  output logic      trst_n       // Test reset, low active
);
  // Parked pins: clock low and reset released until a scenario asks
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
    tms_driven = 1'h1;
    tdi_driven = 1'h1;
    trst_n = 1'h1;
  end

  // One test clock period of 40 system clocks, samples taken mid-phase
  task automatic step(input logic m, input logic d, input logic drive,
                      output logic pre_tdo, output logic pre_oe, output logic mid_tdo);
    tms_driven = drive;
    tdi_driven = drive;
    tms = drive ? m : ~tms;  // Released line never shows its stale level
    tdi = drive ? d : ~tdi;
    repeat (10) @(negedge clk);
    pre_tdo = tdo;
    pre_oe = tdo_oe;
    repeat (10) @(negedge clk);
    tck = 1'h1;
    repeat (10) @(negedge clk);
    mid_tdo = tdo;
    repeat (10) @(negedge clk);
    tck = 1'h0;
  endtask

  // Test reset level change, off the sampling edge
  task automatic set_trst(input logic v);
    @(negedge clk);
    trst_n = v;
  endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
module testbench;
  import bst_pkg::*;
  localparam logic [ID_LEN-1:0] ID_VAL = 32'h1234_5001;  // Arbitrary value, as the design's
  logic     clk, rst, tck, tms, tms_driven, tdi, tdi_driven, trst_n, tdo, tdo_oe, fifo_out_hiz;
  int       fails, comparisons, st;
  bit [31:0] seed = 32'd99525;
  bit [31:0] sreg;
  logic [3:0] ir;
  bit       was_reset;
  // Sixteen-state table, index order of the design's state enum
  int       n0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
  int       n1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};

  bst_tap dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tms_driven(tms_driven),
    .tdi(tdi), .tdi_driven(tdi_driven), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
    .fifo_out_hiz(fifo_out_hiz));
  bst_host host (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven), .trst_n(trst_n));

  always #2 clk = ~clk;

  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic seen, input logic exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Model reaction to one rising test clock edge
  task automatic model_rise(input logic m, input logic d);
    int len;
    len = (st == 11) ? IR_LEN : ((ir == INSTR_IDCODE) ? ID_LEN : 1);
    if (st == 3) sreg = (ir == INSTR_IDCODE) ? ID_VAL : 32'(BYPASS_CAPTURE);
    if (st == 10) sreg = 32'(IR_CAPTURE);
    if (st == 4 || st == 11) sreg = (sreg >> 1) | (32'(d) << (len - 1));
    if (st == 15) ir = sreg[3:0];
    st = m ? n1[st] : n0[st];
    if (st == 0) was_reset = 1'b1;
    if (st == 0) ir = INSTR_IDCODE;
  endtask

  // One test clock period, compared against the model
  task automatic bit_step(input logic m, input logic d, input logic drv);
    logic pre_tdo, pre_oe, mid_tdo, oe_exp;
    oe_exp = (st == 4 || st == 11);
    check(fifo_out_hiz, !was_reset);
    host.step(m, d, drv, pre_tdo, pre_oe, mid_tdo);
    check(pre_oe, oe_exp);
    if (oe_exp) check(pre_tdo, sreg[0]);
    check(mid_tdo, pre_tdo);
    model_rise(drv ? m : 1'b1, drv ? d : 1'b1);
  endtask

  // Full scan through either path, with a pause halfway on long shifts
  task automatic scan(input bit is_ir, input int n, input bit [31:0] data);
    bit_step(1'h0, rnd() & 1, 1'h1);
    bit_step(1'h1, rnd() & 1, 1'h1);
    if (is_ir) bit_step(1'h1, rnd() & 1, 1'h1);
    bit_step(1'h0, rnd() & 1, 1'h1);
    bit_step(1'h0, rnd() & 1, 1'h1);
    for (int i = 0; i < n; i++)
    begin
      bit_step(i == n - 1 || (n > 2 && i == n / 2), data[i], 1'h1);
      if (n > 2 && i == n / 2)
      begin
        bit_step(1'h0, 1'h0, 1'h1);
        bit_step(1'h0, 1'h1, 1'h1);
        bit_step(1'h1, 1'h0, 1'h1);
        bit_step(1'h0, 1'h1, 1'h1);
      end
    end
    bit_step(1'h1, rnd() & 1, 1'h1);
    bit_step(1'h0, rnd() & 1, 1'h1);
  endtask

  // Hang guard
  initial
  begin
    #200000;
    fails++;
    wrap_up;
  end

  initial
  begin
    clk = 1'h0;
    rst = 1'h1;
    st = 1;
    ir = INSTR_IDCODE;
    was_reset = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'h0;
    // No reset yet: outputs float, IR capture seen, pull-ups then walk to reset
    bit_step(1'h1, 1'h0, 1'h1);
    bit_step(1'h1, 1'h0, 1'h1);
    bit_step(1'h0, 1'h0, 1'h1);
    bit_step(1'h0, 1'h0, 1'h1);
    repeat (5) bit_step(1'h0, 1'h0, 1'h0);
    scan(1'b0, ID_LEN, rnd());
    // Every instruction kind, then a data scan through the chosen path
    for (int k = 0; k < 3; k++)
    begin
      scan(1'b1, IR_LEN, (k == 0) ? INSTR_IDCODE : ((k == 1) ? INSTR_BYPASS : rnd()));
      scan(1'b0, 8, rnd());
    end
    // System reset drops readiness; test reset restores it with no clock
    @(negedge clk) rst = 1'h1;
    @(negedge clk) rst = 1'h0;
    st = 1;
    was_reset = 1'b0;
    check(fifo_out_hiz, 1'h1);
    // Test reset pulsed as if tied to the FIFO master reset input
    host.set_trst(1'h0);
    #1 check(fifo_out_hiz, 1'h0);
    host.set_trst(1'h1);
    st = 0;
    was_reset = 1'b1;
    ir = INSTR_IDCODE;
    scan(1'b0, ID_LEN, rnd());
    // Port left unused: clock parked low, test reset grounded, output floats
    host.set_trst(1'h0);
    repeat (20) @(negedge clk);
    check(tdo_oe, 1'h0);
    check(fifo_out_hiz, 1'h0);
    wrap_up;
  end
endmodule
